// file: core/pmr_consts.vh
`ifndef PMR_CONSTS_VH
`define PMR_CONSTS_VH

// Address bit positions of the configuration fields.
`define PMR_RET_PORTION_LO 0
`define PMR_RET_PORTION_HI 1
`define PMR_RET_HALF_BIT 2
`define PMR_RET_MODE_LO 3
`define PMR_RET_MODE_HI 4
`define PMR_BURST_SIZE_LO 5
`define PMR_BURST_SIZE_HI 7
`define PMR_BURST_ORDER_BIT 8
`define PMR_LATENCY_LO 9
`define PMR_LATENCY_HI 11
`define PMR_READY_POL_BIT 13
`define PMR_BUS_MODE_LO 14
`define PMR_BUS_MODE_HI 15
`define PMR_DRIVE_LO 16
`define PMR_DRIVE_HI 17

// Field encodings.
`define PMR_DRIVE_FULL 2'h0
`define PMR_DRIVE_HALF 2'h1
`define PMR_DRIVE_QUARTER 2'h2
`define PMR_MODE_ASYNC 2'h0
`define PMR_MODE_SYNC_RD 2'h1
`define PMR_MODE_SYNC_RW 2'h2
`define PMR_BURST_4 3'h2
`define PMR_BURST_8 3'h3
`define PMR_BURST_16 3'h4
`define PMR_BURST_256 3'h7
`define PMR_LAT_3 3'h0
`define PMR_LAT_6 3'h3
`define PMR_LAT_BASE 3'h3
`define PMR_RET_ENABLE 2'h2
`define PMR_RET_DISABLE 2'h3

// Per-field defaults used after reset and for reserved codes.
`define PMR_DEF_DRIVE 2'h0
`define PMR_DEF_MODE 2'h0
`define PMR_DEF_READY_POL 1'h0
`define PMR_DEF_LATENCY 3'h2
`define PMR_DEF_ORDER 1'h0
`define PMR_DEF_BURST 3'h2
`define PMR_DEF_RET_MODE 2'h3
`define PMR_DEF_RET_HALF 1'h0
`define PMR_DEF_RET_PORTION 2'h0

// Timing figures in nanoseconds and clock period.
`define PMR_CLK_PERIOD_NS 8
`define PMR_SUSPEND_NS 500
`define PMR_RANDOM_READ_NS 70
`define PMR_PAGE_READ_NS 25

`endif

// file: core/pmr_mode_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "pmr_consts.vh"

module pmr_mode_decode #(
    parameter SUSPEND_CYCLES = `PMR_SUSPEND_NS / `PMR_CLK_PERIOD_NS,
    parameter RANDOM_CYCLES = (`PMR_RANDOM_READ_NS + `PMR_CLK_PERIOD_NS - 1) / `PMR_CLK_PERIOD_NS,
    parameter PAGE_CYCLES = (`PMR_PAGE_READ_NS + `PMR_CLK_PERIOD_NS - 1) / `PMR_CLK_PERIOD_NS
) (
    // System.
    input wire clock,
    input wire reset,
    // Memory pins, active low strobes.
    input wire chip_select_n,
    input wire mode_set_pin_n,
    input wire output_enable_n,
    input wire write_enable_n,
    input wire low_byte_enable_n,
    input wire high_byte_enable_n,
    input wire addr_valid_strobe_n,
    input wire link_clk,
    input wire [22:0] address,
    // Data lane enables.
    output reg low_data_oe_r,
    output reg high_data_oe_r,
    // Ready pin.
    output reg ready_out_r,
    output reg ready_oe_r,
    // Decoded configuration.
    output reg [1:0] drive_strength_field_r,
    output reg [1:0] bus_mode_field_r,
    output reg ready_polarity_r,
    output reg [2:0] latency_clocks_r,
    output reg burst_order_field_r,
    output reg [8:0] burst_words_r,
    output reg retention_subset_mode_r,
    output reg retention_half_select_r,
    output reg [1:0] retention_portion_r,
    // Status.
    output reg retention_active_r,
    output reg burst_cmd_r,
    output reg burst_is_write_r,
    output reg page_data_valid_r
);

// ****************************************************************
// Input synchronisers
// ****************************************************************
localparam NSYNC = 31;
reg [NSYNC-1:0] s1_r;
reg [NSYNC-1:0] s2_r;
wire [NSYNC-1:0] raw_in = {address, link_clk, addr_valid_strobe_n, high_byte_enable_n,
    low_byte_enable_n, write_enable_n, output_enable_n, mode_set_pin_n, chip_select_n};

always @(posedge clock)
begin
    s1_r <= raw_in;
    s2_r <= s1_r;
end

wire cs_n = s2_r[0];
wire ms_n = s2_r[1];
wire oe_n = s2_r[2];
wire we_n = s2_r[3];
wire lb_n = s2_r[4];
wire ub_n = s2_r[5];
wire av_n = s2_r[6];
wire lclk = s2_r[7];
wire [22:0] a = s2_r[30:8];

// ****************************************************************
// Configuration register load and decode
// ****************************************************************
wire load_req = ~cs_n & ~av_n & ~we_n & ~lb_n & ~ub_n & ~ms_n & oe_n;
reg load_prev_r;
wire load_now = load_req & ~load_prev_r;
wire async_mode = (bus_mode_field_r == `PMR_MODE_ASYNC);

wire [1:0] f_drive = a[`PMR_DRIVE_HI:`PMR_DRIVE_LO];
wire [1:0] f_mode = a[`PMR_BUS_MODE_HI:`PMR_BUS_MODE_LO];
wire [2:0] f_lat = a[`PMR_LATENCY_HI:`PMR_LATENCY_LO];
wire [2:0] f_burst = a[`PMR_BURST_SIZE_HI:`PMR_BURST_SIZE_LO];
wire [1:0] f_ret = a[`PMR_RET_MODE_HI:`PMR_RET_MODE_LO];

reg [8:0] burst_dec;
always @*
begin
    case (f_burst)
        `PMR_BURST_4: burst_dec = 9'h004;
        `PMR_BURST_8: burst_dec = 9'h008;
        `PMR_BURST_16: burst_dec = 9'h010;
        `PMR_BURST_256: burst_dec = 9'h100;
        default: burst_dec = 9'h004;
    endcase
end

// Reserved drive, mode and latency codes decode to the field defaults, so a
// stray host write can never leave a field in an undefined state.
reg [1:0] drive_dec;
reg [1:0] mode_dec;
reg [2:0] lat_dec;
always @*
begin
    case (f_drive)
        `PMR_DRIVE_FULL: drive_dec = `PMR_DRIVE_FULL;
        `PMR_DRIVE_HALF: drive_dec = `PMR_DRIVE_HALF;
        `PMR_DRIVE_QUARTER: drive_dec = `PMR_DRIVE_QUARTER;
        default: drive_dec = `PMR_DEF_DRIVE;
    endcase
    case (f_mode)
        `PMR_MODE_ASYNC: mode_dec = `PMR_MODE_ASYNC;
        `PMR_MODE_SYNC_RD: mode_dec = `PMR_MODE_SYNC_RD;
        `PMR_MODE_SYNC_RW: mode_dec = `PMR_MODE_SYNC_RW;
        default: mode_dec = `PMR_DEF_MODE;
    endcase
    if (f_lat > `PMR_LAT_6)
        lat_dec = `PMR_DEF_LATENCY + `PMR_LAT_BASE;
    else
        lat_dec = f_lat + `PMR_LAT_BASE;
end

always @(posedge clock)
begin
    if (reset)
    begin
        load_prev_r <= 1'b0;
        drive_strength_field_r <= `PMR_DEF_DRIVE;
        bus_mode_field_r <= `PMR_DEF_MODE;
        ready_polarity_r <= `PMR_DEF_READY_POL;
        latency_clocks_r <= `PMR_DEF_LATENCY + `PMR_LAT_BASE;
        burst_order_field_r <= `PMR_DEF_ORDER;
        burst_words_r <= 9'h004;
        retention_subset_mode_r <= 1'b0;
        retention_half_select_r <= `PMR_DEF_RET_HALF;
        retention_portion_r <= `PMR_DEF_RET_PORTION;
    end
    else
    begin
        load_prev_r <= load_req;
        if (load_now)
        begin
            drive_strength_field_r <= drive_dec;
            bus_mode_field_r <= mode_dec;
            ready_polarity_r <= a[`PMR_READY_POL_BIT];
            latency_clocks_r <= lat_dec;
            burst_order_field_r <= a[`PMR_BURST_ORDER_BIT];
            burst_words_r <= burst_dec;
            retention_subset_mode_r <= (f_ret == `PMR_RET_ENABLE);
            retention_half_select_r <= a[`PMR_RET_HALF_BIT];
            retention_portion_r <= a[`PMR_RET_PORTION_HI:`PMR_RET_PORTION_LO];
        end
    end
end

// ****************************************************************
// Retention entry from standby
// ****************************************************************
// The count restarts whenever the pin rises, so a short mode-set pulse around
// a configuration write never drops the device into retention.
reg [15:0] suspend_cnt_r;
always @(posedge clock)
begin
    if (reset)
    begin
        suspend_cnt_r <= 16'h0000;
        retention_active_r <= 1'b0;
    end
    else if (ms_n)
    begin
        suspend_cnt_r <= 16'h0000;
        retention_active_r <= 1'b0;
    end
    else if (cs_n)
    begin
        // Mode-set low while deselected counts toward retention entry.
        if (suspend_cnt_r < SUSPEND_CYCLES[15:0])
            suspend_cnt_r <= suspend_cnt_r + 16'h0001;
        else if (retention_subset_mode_r)
            retention_active_r <= 1'b1;
    end
end

// ****************************************************************
// Burst command capture on link clock edges
// ****************************************************************
reg lclk_prev_r;
reg av_taken_r;
wire lclk_rise = lclk & ~lclk_prev_r;
always @(posedge clock)
begin
    if (reset)
    begin
        lclk_prev_r <= 1'b0;
        av_taken_r <= 1'b0;
        burst_cmd_r <= 1'b0;
        burst_is_write_r <= 1'b0;
    end
    else
    begin
        lclk_prev_r <= lclk;
        burst_cmd_r <= 1'b0;
        if (async_mode | cs_n | av_n | ~ms_n)
            av_taken_r <= 1'b0;
        else if (lclk_rise & ~av_taken_r)
        begin
            av_taken_r <= 1'b1;
            burst_cmd_r <= 1'b1;
            burst_is_write_r <= ~we_n & (bus_mode_field_r == `PMR_MODE_SYNC_RW);
        end
    end
end

// ****************************************************************
// Ready pin and data lane drive
// ****************************************************************
wire reading = ~cs_n & ms_n & ~oe_n & we_n;
always @(posedge clock)
begin
    if (reset)
    begin
        ready_oe_r <= 1'b0;
        ready_out_r <= 1'b0;
        low_data_oe_r <= 1'b0;
        high_data_oe_r <= 1'b0;
    end
    else
    begin
        ready_oe_r <= ~async_mode & ~cs_n;
        ready_out_r <= ~ready_polarity_r;
        low_data_oe_r <= reading & ~lb_n;
        high_data_oe_r <= reading & ~ub_n;
    end
end

// ****************************************************************
// Asynchronous page read timing
// ****************************************************************
reg [20:0] page_addr_r;
reg [1:0] word_addr_r;
reg page_open_r;
reg [7:0] read_cnt_r;
always @(posedge clock)
begin
    if (reset)
    begin
        page_addr_r <= 21'h000000;
        word_addr_r <= 2'h0;
        page_open_r <= 1'b0;
        read_cnt_r <= 8'h00;
        page_data_valid_r <= 1'b0;
    end
    else if (~reading | ~async_mode)
    begin
        page_open_r <= 1'b0;
        read_cnt_r <= 8'h00;
        page_data_valid_r <= 1'b0;
    end
    else if (~page_open_r | (a[22:2] != page_addr_r))
    begin
        page_open_r <= 1'b1;
        page_addr_r <= a[22:2];
        word_addr_r <= a[1:0];
        read_cnt_r <= RANDOM_CYCLES[7:0] - 8'h01;
        page_data_valid_r <= 1'b0;
    end
    else if (a[1:0] != word_addr_r)
    begin
        word_addr_r <= a[1:0];
        read_cnt_r <= PAGE_CYCLES[7:0] - 8'h01;
        page_data_valid_r <= 1'b0;
    end
    else if (read_cnt_r != 8'h00)
        read_cnt_r <= read_cnt_r - 8'h01;
    else
        page_data_valid_r <= 1'b1;
end

endmodule
`default_nettype wire

// file: tb/pmr_mode_decode_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Checker on the decoder's ports.
// ****************************************
module pmr_mode_decode_props (
    // System.
    input wire logic clock,
    input wire logic reset,
    // Pins and outputs.
    input wire logic mode_set_pin_n,
    input wire logic low_byte_enable_n,
    input wire logic high_byte_enable_n,
    input wire logic low_data_oe_r,
    input wire logic high_data_oe_r,
    input wire logic ready_oe_r,
    input wire logic [1:0] drive_strength_field_r,
    input wire logic [1:0] bus_mode_field_r,
    input wire logic [2:0] latency_clocks_r,
    input wire logic [8:0] burst_words_r,
    input wire logic burst_cmd_r
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    property p_drive; drive_strength_field_r != 2'h3; endproperty
    a_drive: assert property (p_drive) else $error("drive code");
    property p_mode; bus_mode_field_r != 2'h3; endproperty
    a_mode: assert property (p_mode) else $error("bus mode code");
    property p_lat; latency_clocks_r inside {[3'h3:3'h6]}; endproperty
    a_lat: assert property (p_lat) else $error("latency");
    property p_words; burst_words_r inside {9'h4, 9'h8, 9'h10, 9'h100}; endproperty
    a_words: assert property (p_words) else $error("burst words");
    property p_pulse; burst_cmd_r |=> !burst_cmd_r; endproperty
    a_pulse: assert property (p_pulse) else $error("burst pulse");
    property p_cmd_sync; burst_cmd_r |-> bus_mode_field_r != 2'h0; endproperty
    a_cmd_sync: assert property (p_cmd_sync) else $error("burst in async");
    property p_rdy_z; (bus_mode_field_r == 2'h0) [*2] |-> !ready_oe_r; endproperty
    a_rdy_z: assert property (p_rdy_z) else $error("ready driven");
    property p_lane_lo; low_byte_enable_n [*5] |-> !low_data_oe_r; endproperty
    a_lane_lo: assert property (p_lane_lo) else $error("low lane");
    property p_lane_hi; high_byte_enable_n [*5] |-> !high_data_oe_r; endproperty
    a_lane_hi: assert property (p_lane_hi) else $error("high lane");
    property p_load; $changed(bus_mode_field_r) |-> $past(reset) || !$past(mode_set_pin_n, 3) ||
        !$past(mode_set_pin_n, 4) || !$past(mode_set_pin_n, 5); endproperty
    a_load: assert property (p_load) else $error("load source");
endmodule
bind pmr_mode_decode pmr_mode_decode_props u_props (.clock(clock), .reset(reset),
    .mode_set_pin_n(mode_set_pin_n), .low_byte_enable_n(low_byte_enable_n),
    .high_byte_enable_n(high_byte_enable_n), .low_data_oe_r(low_data_oe_r), .high_data_oe_r(high_data_oe_r),
    .ready_oe_r(ready_oe_r), .drive_strength_field_r(drive_strength_field_r), .bus_mode_field_r(bus_mode_field_r),
    .latency_clocks_r(latency_clocks_r), .burst_words_r(burst_words_r), .burst_cmd_r(burst_cmd_r));
`default_nettype wire

// file: tb/pmr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host controller model.
// ****************************************
module pmr_host_model (
    // System.
    input wire logic clock,
    // Pins toward the memory.
    output var logic chip_select_n,
    output var logic mode_set_pin_n,
    output var logic output_enable_n,
    output var logic write_enable_n,
    output var logic low_byte_enable_n,
    output var logic high_byte_enable_n,
    output var logic addr_valid_strobe_n,
    output var logic link_clk,
    output var logic [22:0] address
);
    logic lk_run = 1'b0;
    initial {chip_select_n, mode_set_pin_n, output_enable_n, write_enable_n} = 4'hf;
    initial {low_byte_enable_n, high_byte_enable_n, addr_valid_strobe_n, address} = {3'h7, 23'h0};
    // The memory clock runs only inside a burst frame, off the system clock edges except at multiples of 500 ns.
    initial link_clk = 1'b0;
    always #62.5 link_clk = lk_run & ~link_clk;
    task automatic drive(input logic [6:0] p, input logic [22:0] a, input int n);
        @(posedge clock);
        {chip_select_n, mode_set_pin_n, output_enable_n, write_enable_n} <= p[6:3];
        {low_byte_enable_n, high_byte_enable_n, addr_valid_strobe_n} <= p[2:0];
        address <= a;
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic mode_write(input logic [22:0] a);
        if (a[15:14] == 2'h2)
            drive(7'h31, ~a, 4);
        drive(7'h10, a, 6);
        drive(7'h5f, a, 1);
        drive(7'h7f, ~a, 6);
    endtask
    task automatic burst(input logic wr_n);
        drive({3'h3, wr_n, 3'h0}, address, 0);
        lk_run = 1'b1;
        repeat (60) @(posedge clock);
        lk_run = 1'b0;
        drive(7'h7f, ~address, 8);
    endtask
endmodule
`default_nettype wire

// file: tb/psram_mode_register_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Decoder bench.
// ****************************************
module psram_mode_register_decode_tb;
    localparam int SUSP = 4;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic cs_n, ms_n, oe_n, we_n, lb_n, ub_n, adv_n, lk, lo_oe, hi_oe, rdy, rdy_oe, pol, order;
    logic subset, half, ret_on, cmd, is_wr, pg_ok;
    logic [1:0] drv, mode, portion;
    logic [2:0] lat;
    logic [8:0] words;
    logic [22:0] adr, a;
    int mismatches = 0, n_checks = 0, cyc = 0, bursts = 0, seed = 32'h174b5dcc;
    always #4 clock = ~clock;
    pmr_host_model host (.clock(clock), .chip_select_n(cs_n), .mode_set_pin_n(ms_n), .output_enable_n(oe_n),
        .write_enable_n(we_n), .low_byte_enable_n(lb_n), .high_byte_enable_n(ub_n), .addr_valid_strobe_n(adv_n),
        .link_clk(lk), .address(adr));
    pmr_mode_decode #(.SUSPEND_CYCLES(SUSP)) DUT (.clock(clock), .reset(reset), .chip_select_n(cs_n),
        .mode_set_pin_n(ms_n), .output_enable_n(oe_n), .write_enable_n(we_n), .low_byte_enable_n(lb_n),
        .high_byte_enable_n(ub_n), .addr_valid_strobe_n(adv_n), .link_clk(lk), .address(adr),
        .low_data_oe_r(lo_oe), .high_data_oe_r(hi_oe), .ready_out_r(rdy), .ready_oe_r(rdy_oe),
        .drive_strength_field_r(drv), .bus_mode_field_r(mode), .ready_polarity_r(pol), .latency_clocks_r(lat),
        .burst_order_field_r(order), .burst_words_r(words), .retention_subset_mode_r(subset),
        .retention_half_select_r(half), .retention_portion_r(portion), .retention_active_r(ret_on),
        .burst_cmd_r(cmd), .burst_is_write_r(is_wr), .page_data_valid_r(pg_ok));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] seen);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [8:0] words_of(input logic [2:0] c);
        case (c)
            3'h3: return 9'h8;
            3'h4: return 9'h10;
            3'h7: return 9'h100;
            default: return 9'h4;
        endcase
    endfunction
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cmd === 1'b1)
            bursts++;
        if (cyc == 20000)
        begin
            mismatches++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        for (int i = 0; i < 40; i++)
        begin
            a = 23'($random(seed));
            if (i < 8)
                {a[17:14], a[11:9], a[7:3]} = {i[1:0], i[1:0], i[2:0], i[2:0], i[1:0]};
            a[12] = 1'b0;
            host.mode_write(a);
            chk("drive", (a[17:16] == 2'h3) ? 9'h0 : 9'(a[17:16]), 9'(drv));
            chk("mode", (a[15:14] == 2'h3) ? 9'h0 : 9'(a[15:14]), 9'(mode));
            chk("polarity", 9'(a[13]), 9'(pol));
            chk("ready level", 9'(!a[13]), 9'(rdy));
            chk("latency", (a[11:9] > 3'h3) ? 9'h5 : 9'(a[11:9]) + 9'h3, 9'(lat));
            chk("order", 9'(a[8]), 9'(order));
            chk("words", words_of(a[7:5]), words);
            chk("subset", 9'(a[4:3] == 2'h2), 9'(subset));
            chk("half", 9'(a[2]), 9'(half));
            chk("portion", 9'(a[1:0]), 9'(portion));
            bursts = 0;
            host.burst(a[0]);
            chk("bursts", 9'(a[15:14] == 2'h1 || a[15:14] == 2'h2), 9'(bursts));
            if (a[15:14] == 2'h1 || a[15:14] == 2'h2)
                chk("is_write", 9'(!a[0] && a[15:14] == 2'h2), 9'(is_wr));
        end
        host.mode_write(23'h10);
        host.drive(7'h5f, 23'h7fffef, SUSP + 12);
        chk("retention on", 9'h1, 9'(ret_on));
        host.drive(7'h7f, 23'h10, 6);
        chk("retention off", 9'h0, 9'(ret_on));
        a = 23'($random(seed));
        host.drive(7'h2b, a, 4);
        chk("page early", 9'h0, 9'(pg_ok));
        chk("lanes", 9'h2, {7'h0, lo_oe, hi_oe});
        host.drive(7'h2b, a, 14);
        chk("page first", 9'h1, 9'(pg_ok));
        chk("ready float", 9'h0, 9'(rdy_oe));
        host.drive(7'h2b, a ^ 23'h1, 4);
        chk("page change", 9'h0, 9'(pg_ok));
        host.drive(7'h2b, a ^ 23'h1, 8);
        chk("page next", 9'h1, 9'(pg_ok));
        host.drive(7'h7f, ~a, 6);
        chk("lanes idle", 9'h0, {7'h0, lo_oe, hi_oe});
        wrap_up();
    end
endmodule
`default_nettype wire
